// ==== verilog/emp_pkg.sv ====
// Purpose: Shared constants and carriers for the external memory port pins.
// Assumes: One core clock at 20 MHz; pins resolved by the bench.
// Notes:   Widths fixed at the port's documented values.
package emp_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 24;
	localparam int ATTR_W = 4;
	localparam int WAIT_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
	localparam logic [DATA_W-1:0] DATA_RST = 24'h000000;
	localparam logic [ATTR_W-1:0] ATTR_IDLE = 4'h0;
	localparam logic [WAIT_W-1:0] WAIT_ZERO = 4'h0;
	localparam logic [WAIT_W-1:0] WAIT_ONE = 4'h1;

	// Access request from the core side
	typedef struct packed {
		logic                  write;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
		logic [ATTR_W-1:0]     attr;
		logic [WAIT_W-1:0]     wait_states;
	} emp_req_t;

	// Pin drive group: value and enable
	typedef struct packed {
		logic [ADDR_W-1:0]     addr;
		logic                  addr_oe;
		logic [DATA_W-1:0]     data;
		logic                  data_oe;
		logic [ATTR_W-1:0]     attr;
		logic                  attr_oe;
		logic                  rd_n;
		logic                  wr_n;
		logic                  strobe_oe;
	} emp_pins_t;

	typedef enum logic [2:0] {
		EMP_IDLE = 3'b001,
		EMP_WAIT = 3'b010,
		EMP_DONE = 3'b100
	} emp_state_t;
endpackage

// ==== verilog/emp_sync.sv ====
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Input is asynchronous to clk.
// Notes:   First stage is read only by the second.
`timescale 1ns/1ps
module emp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;

	// Plain two-stage chain, no reset needed
	always_ff @(posedge clk)
	begin
		stage1 <= d;
		q      <= stage1;
	end
endmodule // emp_sync

// ==== verilog/emp_port.sv ====
// Purpose: Pin control of the external memory expansion port.
// Assumes: Arbiter gives mastership as a level; acknowledge and data are
//          pin inputs and are synchronised before use.
// Notes:   Keeper behaviour is modelled by holding the last driven data.
// Contract
// R1: Stop or wait releases mastership and floats all port outputs.
// R2: Address lines driven only while master, floated otherwise.
// R3: Address held steady when no external access is running.
// R4: Data bus bidirectional while master, drivers floated otherwise.
// R5: Keepers hold last driven data; data ignored during reset.
// R6: Attribute lines act as chip selects or extra address lines.
// R7: By default at most one attribute line asserted at a time.
// R8: Priority-disable bit lets four lines form a sixteen-way code.
// R9: Row strobe mode drives attribute lines with programmable polarity.
// R10: Active-low read strobe while master, floated otherwise.
// R11: Active-low write strobe while master, floated otherwise.
// R12: Cycle completes one clock after acknowledge asserted.
// R13: Zero wait state accesses ignore acknowledge.
// R14: Reset deasserts bus request and returns to bus slave.
// R15: Never read and write together; drive data only on writes.
`timescale 1ns/1ps
module emp_port (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         standby,
	input  wire logic                         need_bus,
	input  wire logic                         bus_grant,
	input  wire logic                         attr_priority_disable,
	input  wire logic                         attr_as_row_strobe,
	input  wire logic [emp_pkg::ATTR_W-1:0]   row_strobe_polarity,
	input  wire logic                         req_valid,
	input  wire emp_pkg::emp_req_t            req,
	output logic                              req_ready,
	output logic                              rsp_valid,
	output logic      [emp_pkg::DATA_W-1:0]   rsp_rdata,
	input  wire logic                         transfer_acknowledge_n,
	input  wire logic [emp_pkg::DATA_W-1:0]   data_in,
	output emp_pkg::emp_pins_t                pins,
	output logic                              bus_request_n,
	output logic                              bus_master
);
	emp_pkg::emp_state_t            state;
	emp_pkg::emp_state_t            next_state;
	emp_pkg::emp_req_t              cur;
	logic [emp_pkg::WAIT_W-1:0]     wait_cnt;
	logic [emp_pkg::ADDR_W-1:0]     addr_q;
	logic [emp_pkg::DATA_W-1:0]     data_q;
	logic [emp_pkg::ATTR_W-1:0]     attr_q;
	logic                           active;
	logic                           ack_n_s;
	logic [emp_pkg::DATA_W-1:0]     din_s;
	logic                           ack_ok;
	logic                           min_done;
	logic                           cycle_end;
	logic [emp_pkg::ATTR_W-1:0]     attr_sel;
	logic [emp_pkg::ATTR_W-1:0]     attr_src;
	logic                           drive_en;

	// Lowest set bit wins, keeps chip selects one-hot
	function automatic logic [emp_pkg::ATTR_W-1:0] one_hot_pick(
		input logic [emp_pkg::ATTR_W-1:0] v);
		return v & (~v + 4'h1);
	endfunction

	emp_sync #(.W(1)) u_ack_sync (
		.clk (clk),
		.d   (transfer_acknowledge_n),
		.q   (ack_n_s)
	);

	emp_sync #(.W(emp_pkg::DATA_W)) u_d_sync (
		.clk (clk),
		.d   (data_in),
		.q   (din_s)
	);

	// Mastership and cycle decode
	assign drive_en  = bus_master & ~standby;                   // see R1
	assign min_done  = (wait_cnt == emp_pkg::WAIT_ZERO);
	assign ack_ok    = (cur.wait_states == emp_pkg::WAIT_ZERO)  // see R13
		| ~ack_n_s;                                             // see R12
	assign cycle_end = (state == emp_pkg::EMP_WAIT) & min_done & ack_ok;
	assign req_ready = drive_en & (state == emp_pkg::EMP_IDLE);

	// Attribute encoding: one-hot, code or row strobe; the request being
	// taken is encoded at the take edge so selects line up with strobes
	assign attr_src = (req_valid && req_ready) ? req.attr : cur.attr;
	assign attr_sel = attr_as_row_strobe ?
		(attr_src ^ row_strobe_polarity) :                      // see R9
		(attr_priority_disable ? attr_src :                     // see R8
		one_hot_pick(attr_src));                                // see R6 R7

	// Cycle sequencer
	always_comb
	begin
		next_state = state;
		case (state)
			emp_pkg::EMP_IDLE:
				if (req_valid && req_ready)
					next_state = emp_pkg::EMP_WAIT;
			emp_pkg::EMP_WAIT:
				if (cycle_end)
					next_state = emp_pkg::EMP_DONE;
			emp_pkg::EMP_DONE:
				next_state = emp_pkg::EMP_IDLE;
			default:
				next_state = emp_pkg::EMP_IDLE;
		endcase
	end

	// Arbitration level; standby gives the bus up
	always_ff @(posedge clk)
	begin
		if (rst || standby)
			bus_master <= 1'b0;                                 // see R14 R1
		else
			bus_master <= bus_grant;
	end

	// Request line: deasserted in reset and standby
	always_ff @(posedge clk)
	begin
		if (rst || standby)
			bus_request_n <= 1'b1;                              // see R14
		else
			bus_request_n <= ~need_bus;
	end

	// State and wait counter; standby aborts into idle
	always_ff @(posedge clk)
	begin
		if (rst || !drive_en)
		begin
			state    <= emp_pkg::EMP_IDLE;
			wait_cnt <= emp_pkg::WAIT_ZERO;
			active   <= 1'b0;
		end
		else
		begin
			state  <= next_state;
			active <= (next_state == emp_pkg::EMP_WAIT);
			if (state == emp_pkg::EMP_IDLE && req_valid)
				wait_cnt <= (req.wait_states == emp_pkg::WAIT_ZERO) ?
					emp_pkg::WAIT_ZERO : req.wait_states - emp_pkg::WAIT_ONE;
			else if (!min_done)
				wait_cnt <= wait_cnt - emp_pkg::WAIT_ONE;
		end
	end

	// Latched request; address kept when idle to save power
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cur    <= '0;
			addr_q <= emp_pkg::ADDR_RST;
			data_q <= emp_pkg::DATA_RST;
			attr_q <= emp_pkg::ATTR_IDLE;
		end
		else
		begin
			if (req_valid && req_ready)
			begin
				cur    <= req;
				addr_q <= req.addr;                             // see R3
				if (req.write)
					data_q <= req.wdata;                        // see R5
			end
			attr_q <= (drive_en && next_state == emp_pkg::EMP_WAIT) ?
				attr_sel :
				(attr_as_row_strobe ? row_strobe_polarity :
				emp_pkg::ATTR_IDLE);
		end
	end

	// Read data captured at completion; ignored in reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= emp_pkg::DATA_RST;                     // see R5
		end
		else
		begin
			rsp_valid <= cycle_end;
			if (cycle_end && !cur.write)
				rsp_rdata <= din_s;
		end
	end

	// Pin drive: everything floats unless master and awake
	always_comb
	begin
		pins.addr      = addr_q;
		pins.addr_oe   = drive_en;                              // see R2
		pins.data      = data_q;                                // see R5
		pins.data_oe   = drive_en & active & cur.write;         // see R4 R15
		pins.attr      = attr_q;
		pins.attr_oe   = drive_en;                              // see R9
		pins.rd_n      = ~(active & ~cur.write);                // see R10
		pins.wr_n      = ~(active & cur.write);                 // see R11 R15
		pins.strobe_oe = drive_en;                              // see R10 R11
	end

	property p_standby_float;
		@(posedge clk) disable iff (rst)
		standby |=> !pins.addr_oe && !pins.data_oe && !pins.strobe_oe;
	endproperty
	a_standby_float: assert property (p_standby_float) // see R1
		else $error("port drives pins in standby");

	property p_addr_float;
		@(posedge clk) disable iff (rst)
		!bus_master |-> !pins.addr_oe;
	endproperty
	a_addr_float: assert property (p_addr_float) // see R2
		else $error("address driven while not master");

	property p_addr_hold;
		@(posedge clk) disable iff (rst)
		(state == emp_pkg::EMP_IDLE) && !(req_valid && req_ready)
		|=> $stable(pins.addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) // see R3
		else $error("address toggled while idle");

	property p_one_hot;
		@(posedge clk) disable iff (rst)
		!attr_priority_disable && !attr_as_row_strobe |=> $onehot0(attr_q);
	endproperty
	a_one_hot: assert property (p_one_hot) // see R7
		else $error("more than one attribute line asserted");

	property p_no_rd_wr;
		@(posedge clk) disable iff (rst)
		!(!pins.rd_n && !pins.wr_n);
	endproperty
	a_no_rd_wr: assert property (p_no_rd_wr) // see R15
		else $error("read and write strobes together");

	property p_data_only_write;
		@(posedge clk) disable iff (rst)
		pins.data_oe |-> !pins.wr_n && bus_master;
	endproperty
	a_data_only_write: assert property (p_data_only_write) // see R4 R15
		else $error("data driven outside a write");

	sequence s_ack_seen;
		(state == emp_pkg::EMP_WAIT) && min_done && !ack_n_s;
	endsequence
	property p_ack_done;
		@(posedge clk) disable iff (rst || standby || !bus_grant)
		s_ack_seen |=> rsp_valid ##1 (state == emp_pkg::EMP_IDLE);
	endproperty
	a_ack_done: assert property (p_ack_done) // see R12
		else $error("cycle not ended one clock after acknowledge");

	property p_zero_wait;
		@(posedge clk) disable iff (rst || standby || !bus_grant)
		(state == emp_pkg::EMP_WAIT) && min_done &&
		(cur.wait_states == emp_pkg::WAIT_ZERO) |=> rsp_valid;
	endproperty
	a_zero_wait: assert property (p_zero_wait) // see R13
		else $error("zero wait access was extended");

	property p_reset_slave;
		@(posedge clk)
		rst |=> bus_request_n && !bus_master;
	endproperty
	a_reset_slave: assert property (p_reset_slave) // see R14
		else $error("bus request or master after reset");
endmodule // emp_port

// ==== test/emp_mem.sv ====
// Purpose: Far-side memory and acknowledge source for the port.
// Assumes: One clock; acknowledge delay set by the bench.
// Notes:   Unselected data lines toggle so stale values never match.
`timescale 1ns/1ps
module emp_mem (
	input  wire logic               clk,
	input  wire emp_pkg::emp_pins_t pins,
	input  wire logic [3:0]         ack_delay,
	output logic                    ack_n,
	output logic [23:0]             rdata
);
	logic [23:0] mem [16];
	logic [23:0] last = 24'h000000;
	logic [3:0]  cnt = 4'h0;
	logic        rd_on;
	logic        wr_on;
	// Strobe decode; delay f means never acknowledge
	assign rd_on = pins.strobe_oe && !pins.rd_n;
	assign wr_on = pins.strobe_oe && !pins.wr_n;
	assign rdata = rd_on ? mem[pins.addr[3:0]] : ~last;
	assign ack_n = !((rd_on || wr_on) && cnt >= ack_delay);
	// Store on writes, count strobe cycles, drop ack between cycles
	always_ff @(posedge clk)
	begin
		if (wr_on && pins.data_oe)
			mem[pins.addr[3:0]] <= pins.data;
		cnt <= (rd_on || wr_on) ? cnt + (cnt != 4'he) : 4'h0;
		last <= rdata;
	end
endmodule // emp_mem

// ==== test/external_memory_port_pins_test.sv ====
// Purpose: Self-checking bench for the memory port pins.
// Assumes: 20 MHz clock, synchronous reset held for ten cycles.
// Notes:   Writes are used for timing checks; data input is synchronised.
`timescale 1ns/1ps
module external_memory_port_pins_test;
	logic clk, rst, standby, need_bus, bus_grant, prio_off, rs;
	logic [3:0] pol, ack_delay, attr_seen;
	logic req_valid, req_ready, rsp_valid, ack_pin_n, bus_request_n, bus_master;
	logic [23:0] rsp_rdata, din;
	emp_pkg::emp_req_t req;
	emp_pkg::emp_pins_t pins;
	int n_fail = 0;
	int comparisons = 0;
	int n1, n2;
	logic [13:0] tab [3] = '{14'h00c4, 14'h20cc, 14'h3356};
	emp_port dut (.clk(clk), .rst(rst), .standby(standby),
		.need_bus(need_bus), .bus_grant(bus_grant),
		.attr_priority_disable(prio_off), .attr_as_row_strobe(rs),
		.row_strobe_polarity(pol), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .transfer_acknowledge_n(ack_pin_n),
		.data_in(din), .pins(pins), .bus_request_n(bus_request_n),
		.bus_master(bus_master));
	emp_mem mem (.clk(clk), .pins(pins), .ack_delay(ack_delay),
		.ack_n(ack_pin_n), .rdata(din));
	// Clock at 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One access; n counts falling edges until the response
	task automatic access(input logic w, input logic [17:0] a,
		input logic [23:0] d, input logic [3:0] at, input logic [3:0] ws,
		output int n);
		int k;
		k = 0;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{w, a, d, at, ws};
		@(negedge clk);
		while (req_ready !== 1'b1 && k < 40)
		begin
			@(negedge clk);
			k++;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
			check(pins.rd_n | pins.wr_n, 1'b1);
			if (pins.strobe_oe === 1'b1 && pins.rd_n === 1'b0)
				check(pins.data_oe, 1'b0);
			if (pins.strobe_oe === 1'b1 && (pins.rd_n & pins.wr_n) === 1'b0)
			begin
				attr_seen = pins.attr;
				check({6'h00, pins.addr}, {6'h00, a});
				check(pins.addr_oe, 1'b1);
			end
		end
		check(n < 40, 1'b1);
	endtask
	task automatic t_rw;
		access(1'b1, 18'h2aaa5, 24'h5a3c96, 4'h1, 4'h1, n1);
		check({bus_request_n, bus_master}, 2'h1);
		check(pins.data_oe, 1'b0);
		check(pins.data, 24'h5a3c96);
		repeat (3) @(negedge clk);
		check({6'h00, pins.addr}, 24'h02aaa5);
		access(1'b0, 18'h00005, 24'h000000, 4'h1, 4'h4, n1);
		check(rsp_rdata, 24'h5a3c96);
	endtask
	// Longer acknowledge delay must stretch the cycle by the same amount
	task automatic t_wait;
		ack_delay <= 4'h3;
		access(1'b1, 18'h00001, 24'h000111, 4'h1, 4'h1, n1);
		ack_delay <= 4'h6;
		access(1'b1, 18'h00002, 24'h000222, 4'h1, 4'h1, n2);
		check(n2 - n1, 3);
		ack_delay <= 4'hf;
		access(1'b1, 18'h00003, 24'h000333, 4'h1, 4'h0, n1);
		check(n1, 2);
		ack_delay <= 4'h0;
	endtask
	task automatic t_attr;
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			{prio_off, rs, pol} <= tab[i][13:8];
			access(1'b1, 18'h00004, 24'h000444, tab[i][7:4], 4'h1, n1);
			check(attr_seen, tab[i][3:0]);
		end
		repeat (2) @(negedge clk);
		check(pins.attr, pol);
	endtask
	task automatic t_standby;
		@(posedge clk);
		standby <= 1'b1;
		repeat (2) @(negedge clk);
		check({pins.addr_oe, pins.data_oe, pins.attr_oe, pins.strobe_oe,
			bus_master}, 5'h00);
		@(posedge clk);
		standby <= 1'b0;
		access(1'b1, 18'h00006, 24'h000666, 4'h1, 4'h1, n1);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(negedge clk);
		check({bus_request_n, bus_master, pins.strobe_oe}, 3'h4);
		@(posedge clk);
		rst <= 1'b0;
	endtask
	// Watchdog well beyond the expected hundred or so cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		final_report;
	end
	initial
	begin
		{rst, standby, need_bus, bus_grant, prio_off, rs, pol} = 10'h200;
		{req_valid, ack_delay, req} = '0;
		repeat (10) @(posedge clk);
		check({bus_request_n, bus_master, pins.data_oe}, 3'h4);
		rst <= 1'b0;
		need_bus <= 1'b1;
		bus_grant <= 1'b1;
		t_rw;
		t_wait;
		t_attr;
		t_standby;
		final_report;
	end
endmodule // external_memory_port_pins_test
